// ==== src/adcseq_pkg.sv ====
// Package for the conversion sequencer: register map, field positions, reset
// values, timing counts, bus and analog carriers, and shared address decoders.
// Assumes an 8-bit register port and one system clock where one state is one cycle.
package adcseq_pkg;

  localparam int RES_BITS = 10;
  localparam int NUM_CH = 4;

  // Register offsets on the 8-bit register port.
  localparam logic [7:0] OFS_RES0_LOW = 8'h60;
  localparam logic [7:0] OFS_RES0_HIGH = 8'h61;
  localparam logic [7:0] OFS_RES1_LOW = 8'h62;
  localparam logic [7:0] OFS_RES1_HIGH = 8'h63;
  localparam logic [7:0] OFS_RES2_LOW = 8'h64;
  localparam logic [7:0] OFS_RES2_HIGH = 8'h65;
  localparam logic [7:0] OFS_RES3_LOW = 8'h66;
  localparam logic [7:0] OFS_RES3_HIGH = 8'h67;
  localparam logic [7:0] OFS_MODE = 8'h68;
  localparam logic [7:0] OFS_RATE = 8'h69;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h6A;

  // Field positions in converter_mode_reg.
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_LAUNCH = 2;
  localparam int MODE_RUN = 3;
  localparam int MODE_SCAN = 4;
  localparam int MODE_REPEAT = 5;
  localparam int MODE_BUSY = 6;
  localparam int MODE_END = 7;
  // Field positions in conv_irq_ctrl_reg.
  localparam int IRQ_LEVEL_LSB = 0;
  localparam int IRQ_PEND = 3;

  // Values after reset, and the fill bits of a result low byte.
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [2:0] LEVEL_RST = 3'h0;
  localparam logic [5:0] LOW_FILL = 6'h3F;

  // One conversion at the fastest rate, in states (one state is one sys_clk cycle).
  localparam int CONV_STATES = 160;
  localparam int STATE_NS = 8;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcseq_bus_t;

  typedef struct packed {
    logic [RES_BITS-1:0] tap;
    logic [1:0] chan;
    logic enable;
  } adcseq_ana_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } adcseq_state_t;

  function automatic logic is_result_addr(input logic [7:0] a);
    return a[7:3] == OFS_RES0_LOW[7:3];
  endfunction

  function automatic logic is_high_addr(input logic [7:0] a);
    return is_result_addr(a) && a[0];
  endfunction

endpackage

// ==== src/adcseq_core.sv ====
// Conversion sequencer: mode register, successive-approximation control and
// per-input result storage for a four-input 10-bit converter.
// Assumes an external comparator that answers comp_above for the tap it is given
// within the same step, and a register master that never needs wait states.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

// Function
// - Ten-bit successive approximation over four inputs.
// - Compare input against 1024-step reference taps.
// - Fixed mode converts the selected input only.
// - Scan ascends from input 0 to select.
// - Reset clears input_select to zero.
// - Launch write starts conversion, sets busy.
// - Relaunch abandons conversion, scan restarts at 0.
// - Repeat and scan bits pick four modes.
// - Scan repeat wraps to input 0 forever.
// - Four speeds chosen by rate_select.
// - High speed conversion takes 160 states.
// - Reset clears run control, high speed selected.
// - Single end sets end flag, irq, clears busy.
// - Clearing repeat finishes current conversion first.
// - Halt stops conversion at once, no resume.
// - Separate result per input, overwritten each time.
// - Low byte: two LSBs high, rest ones.
// - High byte holds result bits nine to two.
// - Result bytes are read-only.
// - High byte read clears pending and end flag.
module adcseq_core
  import adcseq_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_STATES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire adcseq_bus_t bus,
  output logic [7:0] rdata,
  input wire logic comp_above,
  input wire logic halt_req,
  output adcseq_ana_t ana,
  output logic conversion_done_irq
);

  localparam int STEP_BASE = CONV_CYCLES / RES_BITS;
  localparam logic [7:0] STEP_LEN0 = 8'(STEP_BASE);

  // The slowest rate shifts the step length left by three; the check allows up to 16,
  // though an eight-bit step counter could serve up to 31 (31 shifted by three is 248).
  generate
    if (CONV_CYCLES % RES_BITS != 0 || STEP_BASE < 1 || STEP_BASE > 16) begin : g_bad_cycles
      $error("CONV_CYCLES must be a multiple of 10 with 1 to 16 cycles per step");
    end
  endgenerate

  adcseq_state_t state, next_state;
  logic [1:0] input_select, next_input_select;
  logic converter_run_control, next_converter_run_control;
  logic scan_select, next_scan_select;
  logic repeat_select, next_repeat_select;
  logic conv_busy_flag, next_conv_busy_flag;
  logic end_flag, next_end_flag;
  logic [1:0] rate_select, next_rate_select;
  logic [2:0] irq_level, next_irq_level;
  logic conv_irq_pending, next_conv_irq_pending;
  logic [1:0] chan, next_chan;
  logic [RES_BITS-1:0] approx, next_approx;
  logic [3:0] bit_idx, next_bit_idx;
  logic [7:0] step_cnt, next_step_cnt;
  logic [RES_BITS-1:0] result [NUM_CH];
  logic [RES_BITS-1:0] next_result [NUM_CH];
  logic [7:0] next_rdata;
  logic [10:0] conv_age, next_conv_age;

  logic wr_mode, launch, abort, hi_read, step_end, conv_end, last_chan, done_single;
  logic [7:0] step_len;
  logic [RES_BITS-1:0] trial, resolved;

  function automatic logic [RES_BITS-1:0] bit_mask(input logic [3:0] idx);
    return 10'h200 >> idx;
  endfunction

  assign wr_mode = bus.wr && bus.addr == OFS_MODE;
  assign launch = wr_mode && bus.wdata[MODE_LAUNCH];
  // Clearing run control stops the comparator, unless the same write relaunches.
  assign abort = halt_req || (wr_mode && !bus.wdata[MODE_RUN] && !launch);
  assign hi_read = bus.rd && is_high_addr(bus.addr);
  assign step_len = STEP_LEN0 << rate_select;
  assign step_end = state == ST_CONV && step_cnt == step_len - 8'h01;
  assign conv_end = step_end && bit_idx == 4'(RES_BITS - 1);
  assign trial = approx | bit_mask(bit_idx);
  assign resolved = comp_above ? trial : approx;
  assign last_chan = !scan_select || chan == input_select;
  assign done_single = conv_end && last_chan && !repeat_select && !abort && !launch;

  // Sequencer and mode state.
  always_comb begin
    next_state = state;
    next_input_select = input_select;
    next_converter_run_control = converter_run_control;
    next_scan_select = scan_select;
    next_repeat_select = repeat_select;
    next_conv_busy_flag = conv_busy_flag;
    next_rate_select = rate_select;
    next_irq_level = irq_level;
    next_chan = chan;
    next_approx = approx;
    next_bit_idx = bit_idx;
    next_step_cnt = step_cnt;
    next_conv_age = conv_age + 11'h001;
    next_result = result;
    if (wr_mode) begin
      next_input_select = bus.wdata[MODE_SEL_LSB +: 2];
      next_converter_run_control = bus.wdata[MODE_RUN];
      next_scan_select = bus.wdata[MODE_SCAN];
      next_repeat_select = bus.wdata[MODE_REPEAT];
    end
    if (bus.wr && bus.addr == OFS_RATE) begin
      next_rate_select = bus.wdata[1:0];
    end
    if (bus.wr && bus.addr == OFS_IRQ_CTRL) begin
      next_irq_level = bus.wdata[IRQ_LEVEL_LSB +: 3];
    end
    if (state == ST_CONV) begin
      next_step_cnt = step_end ? 8'h00 : step_cnt + 8'h01;
      if (step_end) begin
        next_approx = resolved;
        next_bit_idx = bit_idx + 4'h1;
      end
    end
    if (conv_end) begin
      next_result[chan] = resolved;
      next_approx = '0;
      next_bit_idx = 4'h0;
      next_conv_age = 11'h000;
      if (!last_chan) begin
        next_chan = chan + 2'h1;
      end else if (repeat_select) begin
        // Repeat is sampled only here, so clearing it lets this conversion finish.
        next_chan = scan_select ? 2'h0 : input_select;
      end else begin
        next_state = ST_IDLE;
        next_conv_busy_flag = 1'b0;
      end
    end
    if (launch) begin
      next_state = ST_CONV;
      next_conv_busy_flag = 1'b1;
      next_chan = bus.wdata[MODE_SCAN] ? 2'h0 : bus.wdata[MODE_SEL_LSB +: 2];
      next_approx = '0;
      next_bit_idx = 4'h0;
      next_step_cnt = 8'h00;
      next_conv_age = 11'h000;
    end
    if (abort) begin
      // A halted conversion is dropped; release does not restart it.
      next_state = ST_IDLE;
      next_conv_busy_flag = 1'b0;
      next_approx = '0;
      next_bit_idx = 4'h0;
      next_step_cnt = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      input_select <= SEL_RST;
      converter_run_control <= 1'b0;
      scan_select <= 1'b0;
      repeat_select <= 1'b0;
      conv_busy_flag <= 1'b0;
      rate_select <= RATE_RST;
      irq_level <= LEVEL_RST;
      chan <= 2'h0;
      approx <= '0;
      bit_idx <= 4'h0;
      step_cnt <= 8'h00;
      conv_age <= 11'h000;
      for (int i = 0; i < NUM_CH; i++) begin
        result[i] <= '0;
      end
    end else begin
      state <= next_state;
      input_select <= next_input_select;
      converter_run_control <= next_converter_run_control;
      scan_select <= next_scan_select;
      repeat_select <= next_repeat_select;
      conv_busy_flag <= next_conv_busy_flag;
      rate_select <= next_rate_select;
      irq_level <= next_irq_level;
      chan <= next_chan;
      approx <= next_approx;
      bit_idx <= next_bit_idx;
      step_cnt <= next_step_cnt;
      conv_age <= next_conv_age;
      result <= next_result;
    end
  end

  // Completion flags: a completion in the same cycle as a high-byte read wins.
  always_comb begin
    next_end_flag = end_flag;
    next_conv_irq_pending = conv_irq_pending;
    if (hi_read) begin
      next_end_flag = 1'b0;
      next_conv_irq_pending = 1'b0;
    end
    if (done_single) begin
      next_end_flag = 1'b1;
      next_conv_irq_pending = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      end_flag <= 1'b0;
      conv_irq_pending <= 1'b0;
    end else begin
      end_flag <= next_end_flag;
      conv_irq_pending <= next_conv_irq_pending;
    end
  end

  // Read port; results are decoded only for reads, so writes cannot reach them.
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      if (is_result_addr(bus.addr)) begin
        if (bus.addr[0]) begin
          next_rdata = result[bus.addr[2:1]][9:2];
        end else begin
          next_rdata = {result[bus.addr[2:1]][1:0], LOW_FILL};
        end
      end else if (bus.addr == OFS_MODE) begin
        next_rdata = {end_flag, conv_busy_flag, repeat_select, scan_select,
                      converter_run_control, 1'b0, input_select};
      end else if (bus.addr == OFS_RATE) begin
        next_rdata = {6'h00, rate_select};
      end else if (bus.addr == OFS_IRQ_CTRL) begin
        next_rdata = {4'h0, conv_irq_pending, irq_level};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign ana.tap = trial;
  assign ana.chan = chan;
  assign ana.enable = state == ST_CONV;
  // Level zero keeps the request off, as software does during repeat operation.
  assign conversion_done_irq = conv_irq_pending && irq_level != 3'h0;

  a_launch_sets_busy: assert property (@(posedge sys_clk) disable iff (!nrst)
    launch && !halt_req |=> conv_busy_flag && state == ST_CONV && bit_idx == 4'h0)
    else $error("launch did not start a conversion");

  a_fast_conv_len: assert property (@(posedge sys_clk) disable iff (!nrst)
    conv_end && rate_select == 2'h0 |-> conv_age == 11'(CONV_CYCLES - 1))
    else $error("fast conversion length wrong");

  a_single_done: assert property (@(posedge sys_clk) disable iff (!nrst)
    done_single |=> end_flag && conv_irq_pending && !conv_busy_flag && state == ST_IDLE)
    else $error("single completion flags wrong");

  a_start_chan: assert property (@(posedge sys_clk) disable iff (!nrst)
    launch && !halt_req |=> chan == (scan_select ? 2'h0 : input_select))
    else $error("conversion started on wrong input");

  a_scan_next: assert property (@(posedge sys_clk) disable iff (!nrst)
    conv_end && !last_chan && !launch && !abort |=> chan == $past(chan) + 2'h1 && conv_busy_flag)
    else $error("scan did not advance");

  a_scan_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
    conv_end && scan_select && last_chan && repeat_select && !launch && !abort
    |=> chan == 2'h0 && state == ST_CONV)
    else $error("scan repeat did not wrap");

  a_result_store: assert property (@(posedge sys_clk) disable iff (!nrst)
    conv_end && !launch && !abort |=> result[$past(chan)] == $past(resolved))
    else $error("result not stored");

  a_halt_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
    halt_req |=> !conv_busy_flag ##1 (state == ST_IDLE || $past(launch)))
    else $error("halt did not stop conversion");

  a_high_read_clr: assert property (@(posedge sys_clk) disable iff (!nrst)
    hi_read && !done_single |=> !end_flag && !conv_irq_pending)
    else $error("high byte read did not clear flags");

  a_low_fill: assert property (@(posedge sys_clk) disable iff (!nrst)
    bus.rd && is_result_addr(bus.addr) && !bus.addr[0] |=> rdata[5:0] == LOW_FILL)
    else $error("low byte filler wrong");

  a_ro_results: assert property (@(posedge sys_clk) disable iff (!nrst)
    bus.wr && is_result_addr(bus.addr) && !conv_end |=> result[0] == $past(result[0])
    && result[1] == $past(result[1]) && result[2] == $past(result[2])
    && result[3] == $past(result[3]))
    else $error("write changed a result");

  a_step_msb: assert property (@(posedge sys_clk) disable iff (!nrst)
    state == ST_CONV && bit_idx == 4'h0 && step_cnt == 8'h00 |-> ana.tap == 10'h200)
    else $error("first trial is not the top bit");

  a_reset_values: assert property (@(posedge sys_clk)
    $rose(nrst) |-> input_select == SEL_RST && !converter_run_control && rate_select == RATE_RST)
    else $error("mode fields not at reset values");

  a_relaunch_scan: assert property (@(posedge sys_clk) disable iff (!nrst)
    state == ST_CONV && launch && !halt_req && bus.wdata[MODE_SCAN]
    |=> chan == 2'h0 && step_cnt == 8'h00 && bit_idx == 4'h0 && state == ST_CONV)
    else $error("relaunch did not restart the scan");

  a_repeat_exit: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_mode && !bus.wdata[MODE_REPEAT] && !launch && !abort && state == ST_CONV && !conv_end
    |=> state == ST_CONV && conv_busy_flag)
    else $error("leaving repeat abandoned the conversion");

  a_fixed_repeat: assert property (@(posedge sys_clk) disable iff (!nrst)
    conv_end && !scan_select && repeat_select && !launch && !abort
    |=> state == ST_CONV && chan == $past(input_select))
    else $error("fixed repeat did not continue");

  a_high_byte: assert property (@(posedge sys_clk) disable iff (!nrst)
    bus.rd && is_high_addr(bus.addr) |=> rdata == $past(result[bus.addr[2:1]][9:2]))
    else $error("high byte read data wrong");

  a_end_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    end_flag && !hi_read |=> end_flag)
    else $error("end flag cleared without a high byte read");

  a_busy_state: assert property (@(posedge sys_clk) disable iff (!nrst)
    conv_busy_flag == (state == ST_CONV))
    else $error("busy flag disagrees with conversion state");

  a_idle_stays: assert property (@(posedge sys_clk) disable iff (!nrst)
    state == ST_IDLE && !launch |=> state == ST_IDLE)
    else $error("conversion resumed without a launch");

  a_bit_advance: assert property (@(posedge sys_clk) disable iff (!nrst)
    step_end && !conv_end && !launch && !abort
    |=> bit_idx == $past(bit_idx) + 4'h1 && step_cnt == 8'h00)
    else $error("approximation step did not advance");

endmodule // adcseq_core

// ==== sim/adcseq_ana_model.sv ====
// Comparator model for the sequencer's far side: one held level per input.
// Assumes the testbench sets the levels and the sequencer judges one tap per step.
`timescale 1ns/1ps
module adcseq_ana_model
  import adcseq_pkg::*;
(
  input wire logic sys_clk,
  input wire adcseq_ana_t ana,
  input wire logic [NUM_CH-1:0][RES_BITS-1:0] levels,
  output logic comp_above
);
  logic wander = 1'b0;

  // Outside a conversion the answer means nothing, so it wanders instead of holding.
  always @(posedge sys_clk) begin
    wander <= ~wander;
  end

  always_comb begin
    if (ana.enable) begin
      comp_above = levels[ana.chan] >= ana.tap;
    end else begin
      comp_above = wander;
    end
  end
endmodule // adcseq_ana_model

// ==== sim/testbench.sv ====
// Self-checking bench for the conversion sequencer over its register port.
// Assumes a comparator model on the analog side and a shortened conversion count.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module testbench
  import adcseq_pkg::*;
;
  localparam int CONV = 20;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic halt_req = 1'b0;
  logic comp_above;
  logic conversion_done_irq;
  logic [7:0] rdata;
  logic [7:0] d;
  adcseq_bus_t bus = '0;
  adcseq_ana_t ana;
  logic [NUM_CH-1:0][RES_BITS-1:0] tab = {10'h15A, 10'h2A5, 10'h000, 10'h3FF};
  logic [NUM_CH-1:0][RES_BITS-1:0] tab2 = {10'h0F0, 10'h0C3, 10'h381, 10'h246};
  logic [NUM_CH-1:0][RES_BITS-1:0] levels;
  int mismatches = 0;
  int n_compared = 0;
  int n;

  always #4 sys_clk = ~sys_clk;

  adcseq_core #(.CONV_CYCLES(CONV)) DUT (.sys_clk(sys_clk), .nrst(nrst), .bus(bus),
    .rdata(rdata), .comp_above(comp_above), .halt_req(halt_req), .ana(ana),
    .conversion_done_irq(conversion_done_irq));
  adcseq_ana_model far_side (.sys_clk(sys_clk), .ana(ana), .levels(levels),
    .comp_above(comp_above));

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Waits for the end of a conversion, by the enable or by the request line.
  task automatic wait_end(input bit by_irq);
    n = 0;
    while ((by_irq ? conversion_done_irq !== 1'b1 : ana.enable === 1'b1) && n < 2000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      final_report();
    end
  endtask

  initial begin
    levels = tab;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(OFS_MODE);
    `CHK(d, 8'h00)
    rd(OFS_RATE);
    `CHK(d, 8'h00)
    rd(8'h70);
    `CHK(d, 8'h00)
    wr(OFS_IRQ_CTRL, 8'h04);
    // Each input converts once at its own rate, boundary levels among them.
    for (int ch = 0; ch < NUM_CH; ch++) begin
      wr(OFS_RATE, 8'(ch));
      wr(OFS_MODE, 8'h0C | 8'(ch));
      `CHK(ana.chan, 2'(ch))
      wait_end(1'b0);
      `CHK(n, CONV << ch)
      `CHK(conversion_done_irq, 1'b1)
      rd(OFS_MODE);
      `CHK(d[7:6], 2'b10)
      rd(8'(OFS_RES0_HIGH + 2 * ch));
      `CHK(d, tab[ch][9:2])
      rd(8'(OFS_RES0_LOW + 2 * ch));
      `CHK(d, {tab[ch][1:0], LOW_FILL})
      rd(OFS_MODE);
      `CHK(d[7], 1'b0)
      `CHK(conversion_done_irq, 1'b0)
    end
    wr(OFS_RES0_HIGH, 8'h00);
    rd(OFS_RES0_HIGH);
    `CHK(d, 8'hFF)
    // Scan of three inputs leaves the fourth result alone.
    levels = tab2;
    wr(OFS_RATE, 8'h00);
    wr(OFS_MODE, 8'h1E);
    wait_end(1'b1);
    for (int ch = 0; ch < NUM_CH; ch++) begin
      rd(8'(OFS_RES0_HIGH + 2 * ch));
      `CHK(d, (ch < 3) ? tab2[ch][9:2] : tab[3][9:2])
    end
    // Relaunch in the middle of the second input restarts the scan.
    wr(OFS_MODE, 8'h1F);
    repeat (CONV + CONV / 2) @(posedge sys_clk);
    #1;
    `CHK(ana.chan, 2'd1)
    wr(OFS_MODE, 8'h1F);
    `CHK(ana.chan, 2'd0)
    wait_end(1'b1);
    rd(OFS_IRQ_CTRL);
    `CHK(d, 8'h0C)
    rd(OFS_RES3_HIGH);
    `CHK(d, tab2[3][9:2])
    // Scan repeat over two inputs with the request level at zero.
    wr(OFS_IRQ_CTRL, 8'h00);
    wr(OFS_MODE, 8'h3D);
    repeat (2 * CONV + CONV / 2) @(posedge sys_clk);
    #1;
    `CHK(ana.chan, 2'd0)
    levels[1] = 10'h2DB;
    repeat (2 * CONV) @(posedge sys_clk);
    rd(OFS_RES1_HIGH);
    `CHK(d, 8'hB6)
    wr(OFS_MODE, 8'h18);
    `CHK(ana.enable, 1'b1)
    repeat (3 * CONV) @(posedge sys_clk);
    #1;
    `CHK(ana.enable, 1'b0)
    // The conversion under way finished, so the end flag rose as in single operation.
    rd(OFS_MODE);
    `CHK(d, 8'h98)
    `CHK(conversion_done_irq, 1'b0)
    // Fixed repeat keeps converting its one input and refreshes that result.
    wr(OFS_MODE, 8'h2E);
    levels[2] = 10'h19C;
    repeat (2 * CONV) @(posedge sys_clk);
    #1;
    `CHK(ana.chan, 2'd2)
    `CHK(ana.enable, 1'b1)
    rd(OFS_RES2_HIGH);
    `CHK(d, 8'h67)
    // Halt in mid-conversion stops it for good.
    wr(OFS_MODE, 8'h0E);
    rd(OFS_MODE);
    `CHK(d[6], 1'b1)
    @(posedge sys_clk);
    halt_req <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK(ana.enable, 1'b0)
    @(posedge sys_clk);
    halt_req <= 1'b0;
    repeat (2 * CONV) @(posedge sys_clk);
    rd(OFS_MODE);
    `CHK(d[6], 1'b0)
    `CHK(ana.enable, 1'b0)
    // Software drops run control without a halt, which ends the conversion at once.
    wr(OFS_MODE, 8'h0E);
    wr(OFS_MODE, 8'h02);
    `CHK(ana.enable, 1'b0)
    // A second reset in mid-run returns the mode and rate fields to their reset values.
    wr(OFS_RATE, 8'h03);
    wr(OFS_MODE, 8'h0B);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(OFS_MODE);
    `CHK(d, 8'h00)
    rd(OFS_RATE);
    `CHK(d, 8'h00)
    final_report();
  end
endmodule // testbench
